/* File: rtl/rqs_consts.vh */
// Purpose: Constants for the receive queue frame status builder
// Assumes: 16-bit queue words, 25 MHz system clock
// Notes:   Register indices are word addresses on the plain register port
`ifndef RQS_CONSTS_VH
`define RQS_CONSTS_VH

`define RQS_ADDR_W            4
`define RQS_REG_STATUS        4'h0
`define RQS_REG_LENGTH        4'h1
`define RQS_REG_CTRL          4'h2
`define RQS_REG_COUNT         4'h3

`define RQS_CTRL_PASS_BAD     0
`define RQS_CTRL_STRIP_CRC    1
`define RQS_CTRL_RESET        2'h0

`define RQS_ST_VALID          15
`define RQS_ST_PORT_HI        9
`define RQS_ST_PORT_LO        8
`define RQS_ST_BCAST          7
`define RQS_ST_MCAST          6
`define RQS_ST_UCAST          5
`define RQS_ST_ETYPE          3
`define RQS_ST_LONG           2
`define RQS_ST_RUNT           1
`define RQS_ST_FCS            0

`define RQS_PORT_ONE          2'h1
`define RQS_PORT_TWO          2'h2

`define RQS_LEN_W             11
`define RQS_MAX_DATA          11'h77C
`define RQS_MAX_FRAME         11'h5EE
`define RQS_MAX_LENFIELD      16'h05DC
`define RQS_MIN_FRAME         11'h040
`define RQS_CRC_BYTES         11'h004
`define RQS_MEM_AW            10
`define RQS_MEM_DEPTH         1024

`endif

/* File: rtl/rqs_word_mem.v */
// Purpose: Receive packet memory, 16-bit words, registered read data
// Assumes: One write and one read port on the system clock
// Notes:   Contents are not reset
`timescale 1ns/1ns
`default_nettype none
`include "rqs_consts.vh"

module rqs_word_mem (
  input  wire                    clock_i,  // System clock
  input  wire                    wr_en_i,  // Write enable
  input  wire [`RQS_MEM_AW-1:0]  wr_addr_i,// Write word address
  input  wire [15:0]             wr_data_i,// Write data
  input  wire [`RQS_MEM_AW-1:0]  rd_addr_i,// Read word address
  output reg  [15:0]             rd_data_o // Read data, one cycle later
);

  reg [15:0] mem_ff [0:`RQS_MEM_DEPTH-1];

  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_ff[rd_addr_i];
  end

endmodule // rqs_word_mem
`default_nettype wire

/* File: rtl/rqs_frame_status.v */
// Purpose: Builds receive status and byte count words leading each queue entry
// Assumes: Byte stream from MAC side on the system clock; sop/eop framing
// Notes:   Queue entry = status word, length word, then frame data words
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rqs_consts.vh"

module rqs_frame_status (
  input  wire                   clock_i,      // System clock, 25 MHz
  input  wire                   rst_n_i,      // Asynchronous reset, active low
  input  wire                   rx_valid_i,   // MAC byte valid
  input  wire                   rx_sop_i,     // First byte of frame
  input  wire                   rx_eop_i,     // Last byte of frame
  input  wire [7:0]             rx_data_i,    // MAC byte
  input  wire [1:0]             rx_port_i,    // Ingress port code, held in frame
  input  wire                   rx_fcs_bad_i, // FCS mismatch, with eop
  input  wire                   rx_coll_i,    // Collision or early end, with eop
  input  wire [`RQS_MEM_AW-1:0] q_rd_addr_i,  // Queue word read address
  input  wire                   q_rd_i,       // Queue read strobe
  output reg  [15:0]            q_rd_data_o,  // Queue read data
  input  wire                   q_release_i,  // Host done with current frame
  input  wire [`RQS_ADDR_W-1:0] reg_addr_i,   // Register address
  input  wire [15:0]            reg_wdata_i,  // Register write data
  input  wire                   reg_wr_i,     // Register write strobe
  input  wire                   reg_rd_i,     // Register read strobe
  output reg  [15:0]            reg_rdata_o,  // Register read data
  output reg                    frame_ready_o,// Frame delivered to host
  output reg                    frame_drop_o  // Bad frame dropped, one pulse
);

  localparam S_IDLE = 2'h0;
  localparam S_RECV = 2'h1;
  localparam S_HDR0 = 2'h2;
  localparam S_HDR1 = 2'h3;

  reg  [1:0]             state_ff;
  reg  [1:0]             nxt_state;
  reg  [10:0]            len_ff;
  reg  [10:0]            nxt_len;
  reg  [7:0]             lo_byte_ff;
  reg  [7:0]             nxt_lo_byte;
  reg  [15:0]            lentype_ff;
  reg  [15:0]            nxt_lentype;
  reg                    bcast_ff;
  reg                    nxt_bcast;
  reg                    mcast_ff;
  reg                    nxt_mcast;
  reg  [1:0]             port_ff;
  reg  [1:0]             nxt_port;
  reg                    fcs_ff;
  reg                    nxt_fcs;
  reg                    runt_ff;
  reg                    nxt_runt;
  reg  [15:0]            status_ff;
  reg  [15:0]            nxt_status;
  reg  [10:0]            count_ff;
  reg  [10:0]            nxt_count;
  reg                    busy_ff;
  reg                    nxt_busy;
  reg  [1:0]             ctrl_ff;
  reg  [1:0]             nxt_ctrl;
  reg  [15:0]            frames_ff;
  reg  [15:0]            nxt_frames;
  reg                    nxt_ready;
  reg                    nxt_drop;
  reg                    rdq_ff;
  reg  [15:0]            nxt_rdata;
  reg                    mem_we;
  reg  [`RQS_MEM_AW-1:0] mem_wa;
  reg  [15:0]            mem_wd;
  wire [15:0]            mem_rd;
  wire [10:0]            fin_len;
  wire [10:0]            stored_len;
  wire                   bad_frame;
  wire                   too_long;
  wire [`RQS_MEM_AW-1:0] data_wa;

  // Frame length including the final byte
  assign fin_len    = len_ff + 11'h001;
  // Stripped CRC is not counted in the stored length
  assign stored_len = (ctrl_ff[`RQS_CTRL_STRIP_CRC] && fin_len >= `RQS_CRC_BYTES) ?
                      fin_len - `RQS_CRC_BYTES : fin_len;
  assign too_long   = fin_len > `RQS_MAX_FRAME;
  assign bad_frame  = too_long | runt_ff | rx_coll_i | fcs_ff | rx_fcs_bad_i;
  // Data words start after the two header words
  assign data_wa    = len_ff[10:1] + 10'h002;

  rqs_word_mem u_mem (
    .clock_i   (clock_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (mem_wa),
    .wr_data_i (mem_wd),
    .rd_addr_i (q_rd_addr_i),
    .rd_data_o (mem_rd)
  );

  always @* begin
    nxt_state   = state_ff;
    nxt_len     = len_ff;
    nxt_lo_byte = lo_byte_ff;
    nxt_lentype = lentype_ff;
    nxt_bcast   = bcast_ff;
    nxt_mcast   = mcast_ff;
    nxt_port    = port_ff;
    nxt_fcs     = fcs_ff;
    nxt_runt    = runt_ff;
    nxt_status  = status_ff;
    nxt_count   = count_ff;
    nxt_busy    = busy_ff;
    nxt_frames  = frames_ff;
    nxt_drop    = 1'b0;
    mem_we      = 1'b0;
    mem_wa      = data_wa;
    mem_wd      = {rx_data_i, lo_byte_ff};
    if (q_release_i) begin
      nxt_busy = 1'b0;
      nxt_status[`RQS_ST_VALID] = 1'b0;
    end
    case (state_ff)
      S_IDLE: begin
        // A frame is only accepted once the host has freed the memory
        if (rx_valid_i && rx_sop_i && !busy_ff && !q_release_i) begin
          nxt_state   = S_RECV;
          nxt_len     = 11'h000;
          nxt_bcast   = 1'b1;
          nxt_mcast   = rx_data_i[0];
          nxt_port    = rx_port_i;
          nxt_fcs     = 1'b0;
          nxt_runt    = 1'b0;
          nxt_lentype = 16'h0000;
          nxt_lo_byte = rx_data_i;
          nxt_status[`RQS_ST_VALID] = 1'b0;
          if (rx_data_i != 8'hFF) begin
            nxt_bcast = 1'b0;
          end
          if (rx_eop_i) begin
            nxt_runt  = 1'b1;
            nxt_len   = 11'h000;
            nxt_state = S_HDR0;
          end else begin
            nxt_len   = 11'h001;
          end
        end
      end
      S_RECV: begin
        if (rx_valid_i) begin
          if (len_ff < 11'h006 && rx_data_i != 8'hFF) begin
            nxt_bcast = 1'b0;
          end
          if (len_ff == 11'h00C) begin
            nxt_lentype[15:8] = rx_data_i;
          end
          if (len_ff == 11'h00D) begin
            nxt_lentype[7:0] = rx_data_i;
          end
          if (len_ff[0]) begin
            // Frame data kept for the first 1916 bytes only, later bytes not written
            mem_we = (len_ff < `RQS_MAX_DATA);
          end else begin
            nxt_lo_byte = rx_data_i;
          end
          if (rx_eop_i) begin
            if (!len_ff[0]) begin
              mem_we = (len_ff < `RQS_MAX_DATA);
              mem_wd = {8'h00, rx_data_i};
            end
            nxt_fcs   = rx_fcs_bad_i;
            nxt_runt  = rx_coll_i || (fin_len < `RQS_MIN_FRAME);
            nxt_state = S_HDR0;
          end else if (len_ff != 11'h7FF) begin
            nxt_len = len_ff + 11'h001;
          end
        end
      end
      S_HDR0: begin
        // Status and length are final only after the last byte
        nxt_status = 16'h0000;
        nxt_status[`RQS_ST_VALID]                     = 1'b1;
        nxt_status[`RQS_ST_PORT_HI:`RQS_ST_PORT_LO]   = port_ff;
        nxt_status[`RQS_ST_BCAST]                     = bcast_ff;
        nxt_status[`RQS_ST_MCAST]                     = mcast_ff;
        nxt_status[`RQS_ST_UCAST]                     = ~mcast_ff;
        // Meaningless on runts; host is expected to skip it
        nxt_status[`RQS_ST_ETYPE] = lentype_ff > `RQS_MAX_LENFIELD;
        nxt_status[`RQS_ST_LONG]  = fin_len > `RQS_MAX_FRAME;
        nxt_status[`RQS_ST_RUNT]  = runt_ff;
        nxt_status[`RQS_ST_FCS]   = fcs_ff;
        nxt_count  = stored_len;
        mem_we     = 1'b1;
        mem_wa     = 10'h000;
        mem_wd     = nxt_status;
        nxt_state  = S_HDR1;
      end
      S_HDR1: begin
        mem_we     = 1'b1;
        mem_wa     = 10'h001;
        mem_wd     = {5'h00, count_ff};
        nxt_state  = S_IDLE;
        if ((status_ff[`RQS_ST_LONG] || status_ff[`RQS_ST_RUNT] || status_ff[`RQS_ST_FCS])
            && !ctrl_ff[`RQS_CTRL_PASS_BAD]) begin
          nxt_drop = 1'b1;
          nxt_status[`RQS_ST_VALID] = 1'b0;
        end else begin
          nxt_busy   = 1'b1;
          nxt_frames = frames_ff + 16'h0001;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    nxt_ready = nxt_busy;
  end

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (reg_wr_i && reg_addr_i == `RQS_REG_CTRL) begin
      nxt_ctrl = reg_wdata_i[1:0];
    end
    case (reg_addr_i)
      `RQS_REG_STATUS: nxt_rdata = status_ff & 16'h83EF;
      `RQS_REG_LENGTH: nxt_rdata = {5'h00, count_ff};
      `RQS_REG_CTRL:   nxt_rdata = {14'h0000, ctrl_ff};
      `RQS_REG_COUNT:  nxt_rdata = frames_ff;
      default:         nxt_rdata = 16'h0000;
    endcase
    if (!reg_rd_i) begin
      nxt_rdata = 16'h0000;
    end
  end

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff      <= S_IDLE;
      len_ff        <= 11'h000;
      lo_byte_ff    <= 8'h00;
      lentype_ff    <= 16'h0000;
      bcast_ff      <= 1'b0;
      mcast_ff      <= 1'b0;
      port_ff       <= 2'h0;
      fcs_ff        <= 1'b0;
      runt_ff       <= 1'b0;
      status_ff     <= 16'h0000;
      count_ff      <= 11'h000;
      busy_ff       <= 1'b0;
      ctrl_ff       <= `RQS_CTRL_RESET;
      frames_ff     <= 16'h0000;
      rdq_ff        <= 1'b0;
      reg_rdata_o   <= 16'h0000;
      frame_ready_o <= 1'b0;
      frame_drop_o  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      len_ff        <= nxt_len;
      lo_byte_ff    <= nxt_lo_byte;
      lentype_ff    <= nxt_lentype;
      bcast_ff      <= nxt_bcast;
      mcast_ff      <= nxt_mcast;
      port_ff       <= nxt_port;
      fcs_ff        <= nxt_fcs;
      runt_ff       <= nxt_runt;
      status_ff     <= nxt_status;
      count_ff      <= nxt_count;
      busy_ff       <= nxt_busy;
      ctrl_ff       <= nxt_ctrl;
      frames_ff     <= nxt_frames;
      rdq_ff        <= q_rd_i;
      reg_rdata_o   <= nxt_rdata;
      frame_ready_o <= nxt_ready;
      frame_drop_o  <= nxt_drop;
    end
  end

  // Queue data gated to the read-data cycle only
  always @* begin
    q_rd_data_o = rdq_ff ? mem_rd : 16'h0000;
  end

endmodule // rqs_frame_status
`default_nettype wire

/* File: verification/rqs_host_model.sv */
// Purpose: Host model that reads the two leading words of each entry
// Assumes: Entry word 0 is status, word 1 is length
// Notes:   Idle address toggles so a stale value never passes
`timescale 1ns/1ns
`default_nettype none
`include "rqs_consts.vh"
module rqs_host_model (
  input  wire logic                   clock_i,       // System clock
  input  wire logic                   frame_ready_i, // Entry waiting
  input  wire logic [7:0]             slow_i,        // Cycles before reading
  input  wire logic [15:0]            q_rd_data_i,   // Queue read data
  output var  logic [`RQS_MEM_AW-1:0] q_rd_addr_o,   // Queue read address
  output var  logic                   q_rd_o,        // Queue read strobe
  output var  logic                   q_release_o,   // Entry finished
  output var  logic [15:0]            st_o,          // Status word seen
  output var  logic [15:0]            len_o,         // Length word seen
  output var  logic                   got_o          // Entry read, one pulse
);
  initial begin
    {q_rd_o, q_release_o, got_o, st_o, len_o} = '0;
    q_rd_addr_o = '0;
    forever begin
      @(posedge clock_i);
      if (frame_ready_i !== 1'b1) begin
        q_rd_addr_o <= ~q_rd_addr_o;
      end else begin
        repeat (slow_i) @(posedge clock_i);
        q_rd_o      <= 1'b1;
        q_rd_addr_o <= 10'h000;
        @(posedge clock_i);
        q_rd_addr_o <= 10'h001;
        @(posedge clock_i);
        st_o        <= q_rd_data_i;
        q_rd_o      <= 1'b0;
        @(posedge clock_i);
        len_o       <= q_rd_data_i;
        q_release_o <= 1'b1;
        got_o       <= 1'b1;
        @(posedge clock_i);
        q_release_o <= 1'b0;
        got_o       <= 1'b0;
      end
    end
  end
endmodule // rqs_host_model
`default_nettype wire

/* File: verification/rqs_frame_status_chk.sv */
// Purpose: Port checks of the receive status builder
// Assumes: One clock, reset active low
// Notes:   Bound into every builder instance
`timescale 1ns/1ns
`default_nettype none
`include "rqs_consts.vh"
module rqs_frame_status_chk (
  input wire logic                   clock_i,       // System clock
  input wire logic                   rst_n_i,       // Reset, active low
  input wire logic                   rx_valid_i,    // Byte valid
  input wire logic                   rx_eop_i,      // Last byte
  input wire logic [`RQS_MEM_AW-1:0] q_rd_addr_i,   // Queue address
  input wire logic                   q_rd_i,        // Queue read
  input wire logic [15:0]            q_rd_data_o,   // Queue data
  input wire logic                   q_release_i,   // Entry release
  input wire logic [`RQS_ADDR_W-1:0] reg_addr_i,    // Register address
  input wire logic                   reg_rd_i,      // Register read
  input wire logic [15:0]            reg_rdata_o,   // Register data
  input wire logic                   frame_ready_o, // Frame delivered
  input wire logic                   frame_drop_o   // Frame dropped
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire st_rd = reg_rd_i && reg_addr_i == `RQS_REG_STATUS;
  wire hd_rd = q_rd_i && q_rd_addr_i == 10'h000 && frame_ready_o;
  property p_qdata_idle; !$past(q_rd_i) |-> q_rd_data_o == 16'h0000; endproperty
  a_qdata_idle: assert property (p_qdata_idle) else $error("queue data outside answer");
  property p_st_resv; st_rd |=> reg_rdata_o[14:10] == 5'h00 && !reg_rdata_o[4]; endproperty
  a_st_resv: assert property (p_st_resv) else $error("status reserved bits set");
  property p_len_resv;
    reg_rd_i && reg_addr_i == `RQS_REG_LENGTH |=> reg_rdata_o[15:11] == 5'h00;
  endproperty
  a_len_resv: assert property (p_len_resv) else $error("length reserved bits set");
  property p_valid_set; st_rd && frame_ready_o && !q_release_i |=> reg_rdata_o[15]; endproperty
  a_valid_set: assert property (p_valid_set) else $error("valid clear while held");
  property p_valid_clr; st_rd && !frame_ready_o |=> !reg_rdata_o[15]; endproperty
  a_valid_clr: assert property (p_valid_clr) else $error("valid set with no frame");
  property p_port; hd_rd |=> q_rd_data_o[15] && q_rd_data_o[9] != q_rd_data_o[8]; endproperty
  a_port: assert property (p_port) else $error("bad port code");
  property p_class; hd_rd |=> (!q_rd_data_o[7] || q_rd_data_o[6]) && (q_rd_data_o[5] != q_rd_data_o[6]); endproperty
  a_class: assert property (p_class) else $error("address class flags");
  property p_hold; frame_ready_o && !q_release_i |=> frame_ready_o; endproperty
  a_hold: assert property (p_hold) else $error("ready fell before release");
  property p_drop; frame_drop_o |=> !frame_drop_o && !frame_ready_o; endproperty
  a_drop: assert property (p_drop) else $error("drop pulse too long");
  property p_answer; rx_valid_i && rx_eop_i && !frame_ready_o |-> ##3 (frame_ready_o ^ frame_drop_o); endproperty
  a_answer: assert property (p_answer) else $error("no answer three cycles after end");
endmodule // rqs_frame_status_chk
bind rqs_frame_status rqs_frame_status_chk i_chk (.clock_i, .rst_n_i, .rx_valid_i, .rx_eop_i,
  .q_rd_addr_i, .q_rd_i, .q_rd_data_o, .q_release_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
  .frame_ready_o, .frame_drop_o);
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the receive status builder
// Assumes: Host model reads status and length of each entry
// Notes:   Drivers queue expected words, monitor compares them
`timescale 1ns/1ns
`default_nettype none
`include "rqs_consts.vh"
module tb;
  logic clock_i = 0, rst_n_i = 0, rx_valid_i = 0, rx_sop_i = 0, rx_eop_i = 0;
  logic rx_fcs_bad_i = 0, rx_coll_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0]  rx_data_i = 0, slow = 0;
  logic [1:0]  rx_port_i = 0;
  logic [3:0]  reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, q_rd_data_o, reg_rdata_o, st, len;
  logic [9:0]  q_rd_addr_i;
  logic        q_rd_i, q_release_i, got, frame_ready_o, frame_drop_o, rd_seen = 0;
  logic        pass = 0, strip = 0;
  logic [31:0] seed = 32'h2D8722EC;
  logic [32:0] fq[$];
  logic [31:0] rq[$];
  int          errors = 0, tests_run = 0, sent = 0, fin = 0, dlv = 0;
  always #20 clock_i = ~clock_i;
  rqs_frame_status i_rqs_frame_status (.clock_i, .rst_n_i, .rx_valid_i, .rx_sop_i, .rx_eop_i,
    .rx_data_i, .rx_port_i, .rx_fcs_bad_i, .rx_coll_i, .q_rd_addr_i, .q_rd_i, .q_rd_data_o,
    .q_release_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .frame_ready_o, .frame_drop_o);
  rqs_host_model i_rqs_host_model (.clock_i, .frame_ready_i(frame_ready_o), .slow_i(slow),
    .q_rd_data_i(q_rd_data_o), .q_rd_addr_o(q_rd_addr_i), .q_rd_o(q_rd_i),
    .q_release_o(q_release_i), .st_o(st), .len_o(len), .got_o(got));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(logic ok, string s);
    tests_run++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, s);
    end
  endtask
  task automatic cmp_reg(logic [31:0] n);
    check((reg_rdata_o & n[31:16]) === (n[15:0] & n[31:16]), "register read");
  endtask
  task automatic cmp_frame(logic [32:0] a);
    logic [32:0] e;
    logic [32:0] m;
    e = fq.pop_front();
    m = {1'b1, e[17] ? 16'hFFF7 : 16'hFFFF, 16'hFFFF};
    fin++;
    check((a & m) === (e & m), "frame words");
  endtask
  always @(posedge clock_i) begin
    if (rd_seen) cmp_reg(rq.pop_front());
    rd_seen = reg_rd_i;
    if (got === 1'b1) cmp_frame({1'b0, st, len});
    if (frame_drop_o === 1'b1) cmp_frame(33'h100000000);
  end
  task automatic bus(logic w, logic r, logic [3:0] a, logic [15:0] d);
    reg_wr_i    <= w;
    reg_rd_i    <= r;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] e);
    rq.push_back({16'hFFFF, e});
    bus(0, 1, a, 16'(rnd()));
  endtask
  task automatic frame(int n, logic [1:0] k, logic [15:0] ty, logic [1:0] p, logic f, logic c);
    logic [15:0] s;
    logic [7:0]  b;
    logic        bad;
    s = {1'b1, 5'h00, p, k == 2, k != 0, k == 0, 1'b0, ty > `RQS_MAX_LENFIELD,
         n > `RQS_MAX_FRAME, c || n < `RQS_MIN_FRAME, f};
    bad = (f | s[2] | s[1]) & !pass;
    fq.push_back(bad ? 33'h100000000 : {1'b0, s, 5'h00, 11'(strip ? n - 4 : n)});
    if (!bad) dlv++;
    for (int i = 0; i < n; i++) begin
      b = 8'(rnd());
      if (i < 6 && k == 2) b = 8'hFF;
      if (i == 0 && k != 2) b[0] = k[0];
      if (i == 12) b = ty[15:8];
      if (i == 13) b = ty[7:0];
      rx_valid_i   <= 1'b1;
      rx_sop_i     <= i == 0;
      rx_eop_i     <= i == n - 1;
      rx_data_i    <= b;
      rx_port_i    <= p;
      rx_fcs_bad_i <= f & (i == n - 1);
      rx_coll_i    <= c & (i == n - 1);
      @(posedge clock_i);
    end
    {rx_valid_i, rx_sop_i, rx_eop_i, rx_fcs_bad_i, rx_coll_i} <= 5'h00;
    sent++;
    if (slow != 0 && !bad) begin
      repeat (4) @(posedge clock_i);
      rd(`RQS_REG_STATUS, s);
      rd(`RQS_REG_LENGTH, {5'h00, 11'(n)});
      rd(4'hF, 16'h0000);
      bus(0, 0, 4'h0, 16'h0000);
    end
    for (int j = 0; j < 300 && fin != sent; j++) @(posedge clock_i);
    repeat (3) @(posedge clock_i);
  endtask
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clock_i);
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(`RQS_REG_CTRL, 16'h0000);
    bus(1, 0, `RQS_REG_STATUS, 16'hFFFF);
    rd(`RQS_REG_STATUS, 16'h0000);
    bus(1, 0, `RQS_REG_CTRL, 16'h0001);
    rd(`RQS_REG_CTRL, 16'h0001);
    bus(0, 0, 4'h0, 16'h0000);
    pass = 1;
    $display("test registers done");
    frame(64, 0, 16'h05DD, 2'h1, 0, 0);
    frame(100, 1, 16'h05DC, 2'h2, 0, 0);
    frame(1518, 2, 16'h0800, 2'h1, 1, 0);
    frame(1519, 0, 16'h0000, 2'h2, 0, 0);
    frame(63, 1, 16'hFFFF, 2'h1, 0, 0);
    frame(80, 0, 16'h0600, 2'h2, 0, 1);
    repeat (4) frame(64 + int'(rnd() % 200), 2'(rnd() % 3), 16'(rnd()), 2'h1, 0, 0);
    slow = 40;
    frame(90, 0, 16'h0800, 2'h2, 0, 0);
    slow = 0;
    $display("test status words done");
    bus(1, 0, `RQS_REG_CTRL, 16'h0003);
    bus(0, 0, 4'h0, 16'h0000);
    strip = 1;
    frame(70, 0, 16'h0800, 2'h1, 0, 0);
    $display("test crc strip done");
    bus(1, 0, `RQS_REG_CTRL, 16'h0000);
    bus(0, 0, 4'h0, 16'h0000);
    {pass, strip} = 2'b00;
    frame(70, 0, 16'h0800, 2'h1, 1, 0);
    frame(63, 0, 16'h0800, 2'h2, 0, 0);
    frame(1519, 1, 16'h0800, 2'h1, 0, 0);
    frame(64, 2, 16'h0800, 2'h2, 0, 0);
    rd(`RQS_REG_COUNT, 16'(dlv));
    bus(0, 0, 4'h0, 16'h0000);
    repeat (2) @(posedge clock_i);
    $display("test bad frame drop done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
